// [rtl/ledi2c_pkg.sv]
package ledi2c_pkg;
  localparam logic [6:0] TARGET_ADDR   = 7'h6b;
  localparam logic [7:0] OFS_SHUTDOWN  = 8'h00;
  localparam logic [7:0] OFS_BREATH    = 8'h01;
  localparam logic [7:0] OFS_MODE      = 8'h02;
  localparam logic [7:0] OFS_CURRENT   = 8'h03;
  localparam logic [7:0] OFS_DUTY0     = 8'h04;
  localparam logic [7:0] OFS_DUTY_LOAD = 8'h07;
  localparam logic [7:0] OFS_START0    = 8'h0a;
  localparam logic [7:0] OFS_RISE0     = 8'h10;
  localparam logic [7:0] OFS_FALL0     = 8'h16;
  localparam logic [7:0] OFS_TIME_LOAD = 8'h1c;
  localparam logic [7:0] OFS_ON_OFF    = 8'h1d;
  localparam logic [7:0] OFS_SOFT_RST  = 8'h2f;
  localparam int         NUM_CH        = 3;
  localparam int         EN_BIT        = 5;
  localparam int         SSD_BIT       = 0;
  localparam logic [7:0] RST_SHUTDOWN  = 8'h01;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [2:0] RST_ON_OFF    = 3'h7;
  localparam logic [7:0] LOAD_VALUE    = 8'h00;
endpackage

// [rtl/ledi2c_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module ledi2c_sync (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic d_in,
  output var  logic q_out
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = d_in;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b1;
      q_out  <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      q_out  <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// [rtl/ledi2c_chreg.sv]
`timescale 1ns/100ps
`default_nettype none
// Staged register with a load strobe into its active copy
module ledi2c_chreg #(
  parameter int         W   = 8,
  parameter logic [7:0] RST = 8'h00
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clr_in,
  input  wire logic         wr_in,
  input  wire logic [W-1:0] wdata_in,
  input  wire logic         load_in,
  output var  logic [W-1:0] active_out
);
  logic [W-1:0] stage_r;
  logic [W-1:0] stage_nxt;
  logic [W-1:0] active_nxt;

  always_comb begin
    stage_nxt  = stage_r;
    active_nxt = active_out;
    if (clr_in) begin
      stage_nxt  = RST[W-1:0];
      active_nxt = RST[W-1:0];
    end else begin
      if (wr_in) begin
        stage_nxt = wdata_in;
      end
      if (load_in) begin
        active_nxt = wr_in ? wdata_in : stage_r;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage_r    <= RST[W-1:0];
      active_out <= RST[W-1:0];
    end else begin
      stage_r    <= stage_nxt;
      active_out <= active_nxt;
    end
  end
endmodule
`default_nettype wire

// [rtl/ledi2c_top.sv]
// Notes on behaviour
// RL1 - Answer only target address 1101011
// RL2 - Controller always sends direction bit zero; bench also sends one, left unacknowledged
// RL3 - Data sampled while clock stably high
// RL4 - Controller leaves data high when idle
// RL5 - Start: data falls while clock high
// RL6 - Address byte shifted most significant first
// RL7 - Pull data low on address acknowledge
// RL8 - Controller stops on missing address acknowledge
// RL9 - Pointer byte received and acknowledged
// RL10 - Data bytes acknowledged, written to pointer
// RL11 - Pointer increments on each data acknowledge
// RL12 - Stop: data rises while clock high
// RL13 - Shutdown register: enable D5, shutdown D0
// RL14 - Duty registers at 04h to 06h
// RL15 - Write 07h loads duty and on/off
// RL16 - Write 1Ch loads staged timing registers
// RL17 - On/off register 1Dh resets to 111
// RL18 - Write 2Fh restores all defaults
// RL19 - Shutdown bit one means software shutdown
// RL20 - Controller writes zero to load registers
// RL21 - Low shutdown pin shuts whole device
// RL22 - Unmapped addresses acknowledged, data dropped
// RL23 - Bus lines synchronised, conditions from samples
`timescale 1ns/100ps
`default_nettype none
module ledi2c_top (
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  input  wire logic                       shutdown_pin_n_in,
  output logic                            device_active_out,
  output logic                            channel_enable_out,
  output logic                            soft_shutdown_bit_out,
  output logic [7:0]                      breathing_control_out,
  output logic [7:0]                      operating_mode_out,
  output logic [7:0]                      current_setting_out,
  output logic [ledi2c_pkg::NUM_CH-1:0]   channel_on_out,
  output logic [ledi2c_pkg::NUM_CH*8-1:0] duty_out,
  output logic [ledi2c_pkg::NUM_CH*8-1:0] start_time_out,
  output logic [ledi2c_pkg::NUM_CH*8-1:0] rise_time_out,
  output logic [ledi2c_pkg::NUM_CH*8-1:0] fall_time_out
);
  typedef enum logic [2:0] {LEDI2C_IDLE, LEDI2C_ADDR, LEDI2C_PTR, LEDI2C_DATA,
                            LEDI2C_ACK, LEDI2C_IGNORE} ledi2c_state_t;

  logic scl_s;
  logic sda_s;
  logic pin_n_s;
  ledi2c_sync u_sync_scl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .d_in(scl_in), .q_out(scl_s)); // see RL23
  ledi2c_sync u_sync_sda (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .d_in(sda_in), .q_out(sda_s)); // see RL23
  ledi2c_sync u_sync_pin (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                          .d_in(shutdown_pin_n_in), .q_out(pin_n_s));

  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s; // see RL5
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s; // see RL12

  ledi2c_state_t state_r;
  ledi2c_state_t state_nxt;
  ledi2c_state_t after_ack_r;
  ledi2c_state_t after_ack_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       ack_drive_r;
  logic       ack_drive_nxt;
  logic       ack_seen_r;
  logic       ack_seen_nxt;
  logic       wr_strobe;
  logic [7:0] wr_data;
  logic       data_byte_r;
  logic       data_byte_nxt;

  always_comb begin
    state_nxt     = state_r;
    after_ack_nxt = after_ack_r;
    shift_nxt     = shift_r;
    bit_cnt_nxt   = bit_cnt_r;
    ptr_nxt       = ptr_r;
    ack_drive_nxt = ack_drive_r;
    ack_seen_nxt  = ack_seen_r;
    wr_strobe     = 1'b0;
    wr_data       = shift_r;
    if (stop_det) begin
      state_nxt     = LEDI2C_IDLE; // see RL12
      ack_drive_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt     = LEDI2C_ADDR; // see RL5
      bit_cnt_nxt   = 4'h0;
      ack_drive_nxt = 1'b0;
    end else begin
      case (state_r)
        LEDI2C_ADDR, LEDI2C_PTR, LEDI2C_DATA: begin
          if (scl_rise) begin
            shift_nxt   = {shift_r[6:0], sda_s}; // see RL3
            bit_cnt_nxt = bit_cnt_r + 4'h1; // see RL6
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_nxt = 4'h0;
            ack_seen_nxt = 1'b0;
            if (state_r == LEDI2C_ADDR) begin
              if (shift_r == {ledi2c_pkg::TARGET_ADDR, 1'b0}) begin // see RL1
                ack_drive_nxt = 1'b1; // see RL7
                after_ack_nxt = LEDI2C_PTR;
                state_nxt     = LEDI2C_ACK;
              end else begin
                state_nxt = LEDI2C_IGNORE;
              end
            end else if (state_r == LEDI2C_PTR) begin
              ptr_nxt       = shift_r; // see RL9
              ack_drive_nxt = 1'b1;
              after_ack_nxt = LEDI2C_DATA;
              state_nxt     = LEDI2C_ACK;
            end else begin
              wr_strobe     = 1'b1; // see RL10
              wr_data       = shift_r;
              ack_drive_nxt = 1'b1; // see RL22
              after_ack_nxt = LEDI2C_DATA;
              state_nxt     = LEDI2C_ACK;
            end
          end
        end
        LEDI2C_ACK: begin
          if (scl_rise) begin
            ack_seen_nxt = 1'b1;
          end else if (scl_fall && ack_seen_r) begin
            ack_drive_nxt = 1'b0;
            state_nxt     = after_ack_r;
          end
        end
        LEDI2C_IDLE, LEDI2C_IGNORE: begin
          state_nxt = state_r;
        end
        default: begin
          state_nxt = LEDI2C_IDLE;
        end
      endcase
    end
  end

  // Pointer advances once per acknowledged data byte
  logic       data_acked;
  logic [7:0] ptr_next_final;
  assign data_acked = (state_r == LEDI2C_ACK) && scl_fall && ack_seen_r &&
                      (after_ack_r == LEDI2C_DATA) && ~stop_det && ~start_det &&
                      data_byte_r;
  assign ptr_next_final = data_acked ? ptr_r + 8'h01 : ptr_nxt; // see RL11

  always_comb begin
    data_byte_nxt = data_byte_r;
    if (wr_strobe) begin
      data_byte_nxt = 1'b1;
    end else if (state_r != LEDI2C_ACK) begin
      data_byte_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      state_r     <= LEDI2C_IDLE;
      after_ack_r <= LEDI2C_IDLE;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 4'h0;
      ptr_r       <= 8'h00;
      ack_drive_r <= 1'b0;
      ack_seen_r  <= 1'b0;
      data_byte_r <= 1'b0;
    end else begin
      scl_d_r     <= scl_s;
      sda_d_r     <= sda_s;
      state_r     <= state_nxt;
      after_ack_r <= after_ack_nxt;
      shift_r     <= shift_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      ptr_r       <= ptr_next_final;
      ack_drive_r <= ack_drive_nxt;
      ack_seen_r  <= ack_seen_nxt;
      data_byte_r <= data_byte_nxt;
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = ack_drive_r; // see RL7

  // Register bank
  logic clr_bank;
  logic duty_load;
  logic time_load;
  assign clr_bank  = wr_strobe && ptr_r == ledi2c_pkg::OFS_SOFT_RST; // see RL18
  assign duty_load = wr_strobe && ptr_r == ledi2c_pkg::OFS_DUTY_LOAD; // see RL15
  assign time_load = wr_strobe && ptr_r == ledi2c_pkg::OFS_TIME_LOAD; // see RL16

  logic [7:0] shutdown_r;
  logic [7:0] shutdown_nxt;
  logic [7:0] breath_nxt;
  logic [7:0] mode_nxt;
  logic [7:0] current_nxt;
  always_comb begin
    shutdown_nxt = shutdown_r;
    breath_nxt   = breathing_control_out;
    mode_nxt     = operating_mode_out;
    current_nxt  = current_setting_out;
    if (clr_bank) begin
      shutdown_nxt = ledi2c_pkg::RST_SHUTDOWN;
      breath_nxt   = ledi2c_pkg::RST_ZERO;
      mode_nxt     = ledi2c_pkg::RST_ZERO;
      current_nxt  = ledi2c_pkg::RST_ZERO;
    end else if (wr_strobe) begin
      case (ptr_r)
        ledi2c_pkg::OFS_SHUTDOWN: shutdown_nxt = wr_data; // see RL13
        ledi2c_pkg::OFS_BREATH:   breath_nxt   = wr_data;
        ledi2c_pkg::OFS_MODE:     mode_nxt     = wr_data;
        ledi2c_pkg::OFS_CURRENT:  current_nxt  = wr_data;
        default:                  shutdown_nxt = shutdown_r; // see RL22
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shutdown_r            <= ledi2c_pkg::RST_SHUTDOWN;
      breathing_control_out <= ledi2c_pkg::RST_ZERO;
      operating_mode_out    <= ledi2c_pkg::RST_ZERO;
      current_setting_out   <= ledi2c_pkg::RST_ZERO;
    end else begin
      shutdown_r            <= shutdown_nxt;
      breathing_control_out <= breath_nxt;
      operating_mode_out    <= mode_nxt;
      current_setting_out   <= current_nxt;
    end
  end

  assign channel_enable_out    = shutdown_r[ledi2c_pkg::EN_BIT]; // see RL13
  assign soft_shutdown_bit_out = shutdown_r[ledi2c_pkg::SSD_BIT];
  assign device_active_out     = pin_n_s & ~shutdown_r[ledi2c_pkg::SSD_BIT]; // see RL19 see RL21

  ledi2c_chreg #(.W(3), .RST({5'h00, ledi2c_pkg::RST_ON_OFF})) u_on_off (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clr_in(clr_bank),
    .wr_in(wr_strobe && ptr_r == ledi2c_pkg::OFS_ON_OFF), .wdata_in(wr_data[2:0]),
    .load_in(duty_load), .active_out(channel_on_out)); // see RL17

  for (genvar c = 0; c < ledi2c_pkg::NUM_CH; c++) begin : g_ch
    ledi2c_chreg u_duty (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clr_in(clr_bank),
      .wr_in(wr_strobe && ptr_r == ledi2c_pkg::OFS_DUTY0 + 8'(c)), .wdata_in(wr_data),
      .load_in(duty_load), .active_out(duty_out[c*8 +: 8])); // see RL14
    ledi2c_chreg u_start (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clr_in(clr_bank),
      .wr_in(wr_strobe && ptr_r == ledi2c_pkg::OFS_START0 + 8'(c)), .wdata_in(wr_data),
      .load_in(time_load), .active_out(start_time_out[c*8 +: 8]));
    ledi2c_chreg u_rise (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clr_in(clr_bank),
      .wr_in(wr_strobe && ptr_r == ledi2c_pkg::OFS_RISE0 + 8'(c)), .wdata_in(wr_data),
      .load_in(time_load), .active_out(rise_time_out[c*8 +: 8]));
    ledi2c_chreg u_fall (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clr_in(clr_bank),
      .wr_in(wr_strobe && ptr_r == ledi2c_pkg::OFS_FALL0 + 8'(c)), .wdata_in(wr_data),
      .load_in(time_load), .active_out(fall_time_out[c*8 +: 8]));
  end

  a_ack_match: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL7
    (state_r == LEDI2C_ADDR && scl_fall && bit_cnt_r == 4'h8 && !start_det && !stop_det &&
     shift_r == {ledi2c_pkg::TARGET_ADDR, 1'b0}) |=> sda_oe_out)
    else $error("address acknowledge not driven");
  a_no_ack_other: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL1
    (state_r == LEDI2C_ADDR && scl_fall && bit_cnt_r == 4'h8 && !start_det && !stop_det &&
     shift_r != {ledi2c_pkg::TARGET_ADDR, 1'b0}) |=> !sda_oe_out)
    else $error("foreign address acknowledged");
  a_ack_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL7
    (state_r == LEDI2C_ACK && sda_oe_out && !scl_fall && !start_det && !stop_det) |=>
    sda_oe_out)
    else $error("acknowledge released early");
  a_ptr_ack: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL9
    (state_r == LEDI2C_PTR && scl_fall && bit_cnt_r == 4'h8 && !start_det && !stop_det) |=>
    sda_oe_out && ptr_r == $past(shift_r))
    else $error("pointer byte not taken");
  a_data_ack: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL10
    wr_strobe |=> sda_oe_out && state_r == LEDI2C_ACK)
    else $error("data byte not acknowledged");
  a_stop_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL12
    stop_det |=> state_r == LEDI2C_IDLE && !sda_oe_out)
    else $error("stop did not end transfer");
  a_start_addr: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL5
    (start_det && !stop_det) |=> state_r == LEDI2C_ADDR && bit_cnt_r == 4'h0)
    else $error("start not taken");
  a_ptr_incr: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL11
    data_acked |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not advance");
  a_unmapped_drop: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL22
    (wr_strobe && ptr_r > ledi2c_pkg::OFS_SOFT_RST) |=> shutdown_r == $past(shutdown_r) &&
    operating_mode_out == $past(operating_mode_out) && channel_on_out == $past(channel_on_out))
    else $error("unmapped write changed the bank");
  a_shutdown_wr: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL13
    (wr_strobe && ptr_r == ledi2c_pkg::OFS_SHUTDOWN) |=>
    channel_enable_out == $past(wr_data[ledi2c_pkg::EN_BIT]) &&
    soft_shutdown_bit_out == $past(wr_data[ledi2c_pkg::SSD_BIT]))
    else $error("shutdown bits not written");
  a_soft_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL18
    clr_bank |=> shutdown_r == ledi2c_pkg::RST_SHUTDOWN && channel_on_out == 3'h7)
    else $error("soft reset missed defaults");
  a_active_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL21
    !pin_n_s |-> !device_active_out)
    else $error("active while pin low");
  a_duty_load: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL15
    (duty_load && !clr_bank) |=> duty_out[7:0] == $past(g_ch[0].u_duty.stage_r))
    else $error("duty not loaded");
  a_on_off_load: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL17
    (duty_load && !clr_bank) |=> channel_on_out == $past(u_on_off.stage_r))
    else $error("on/off not loaded");
  a_time_load: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL16
    (time_load && !clr_bank) |=> fall_time_out[23:16] == $past(g_ch[2].u_fall.stage_r))
    else $error("timing not loaded");
  a_ptr_write: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL10
    (wr_strobe && ptr_r == ledi2c_pkg::OFS_MODE) |=> operating_mode_out == $past(wr_data))
    else $error("mode write lost");
  a_sync_scl: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RL23
    scl_s == $past(scl_in, 2))
    else $error("clock line not synchronised");
  c_addr_ack: cover property (@(posedge clk_in) state_r == LEDI2C_ACK && after_ack_r == LEDI2C_PTR);
  c_data_wr: cover property (@(posedge clk_in) wr_strobe);
  c_duty_load: cover property (@(posedge clk_in) duty_load);
  c_soft_rst: cover property (@(posedge clk_in) clr_bank);
  c_unmapped: cover property (@(posedge clk_in) wr_strobe && ptr_r > ledi2c_pkg::OFS_SOFT_RST);
endmodule
`default_nettype wire

// [tb/ledi2c_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Bus controller, one bit every 8 system clocks (800 ns)
module ledi2c_ctrl_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_drv_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data moves mid low phase, held through the high phase
  task automatic pulse(input logic b, output logic seen);
    logic s0;
    wait_clk(2);
    sda_drv_out <= b;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(2);
    s0 = sda_in;
    wait_clk(2);
    seen = s0 | sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask
  task automatic start_cond();
    wait_clk(4);
    sda_drv_out <= 1'b0;
    wait_clk(4);
    scl_out <= 1'b0;
  endtask
  task automatic stop_cond();
    wait_clk(2);
    sda_drv_out <= 1'b0;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(4);
    sda_drv_out <= 1'b1;
    wait_clk(4);
  endtask
  // Returns the number of acknowledged bytes
  task automatic write(input logic [6:0] addr, input logic dir, input logic [7:0] ptr,
                       input logic [7:0] data[$], output int acks);
    logic ack;
    acks = 0;
    start_cond();
    send_byte({addr, dir}, ack);
    if (ack) begin
      acks++;
      send_byte(ptr, ack);
      acks += int'(ack);
      foreach (data[i]) begin
        send_byte(data[i], ack);
        acks += int'(ack);
      end
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire

// [tb/ledi2c_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module ledi2c_top_bench;
  logic        clk_in;
  logic        sys_rst_in;
  logic        shutdown_pin_n_in;
  wire logic   scl;
  wire logic   sda_drv;
  wire logic   sda_line;
  wire logic   sda_out;
  wire logic   sda_oe_out;
  wire logic   act;
  wire logic   en;
  wire logic   soft_shutdown_bit;
  wire logic [7:0]  breath;
  wire logic [7:0]  mode;
  wire logic [7:0]  cur;
  wire logic [2:0]  on;
  wire logic [23:0] duty;
  wire logic [23:0] st;
  wire logic [23:0] rise;
  wire logic [23:0] fall;
  int          failures;
  int          tests_run;
  localparam logic [6:0] ADR = ledi2c_pkg::TARGET_ADDR;

  // Open-drain data line with pull-up
  assign sda_line = sda_drv & (sda_oe_out ? sda_out : 1'b1);

  ledi2c_top DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .shutdown_pin_n_in(shutdown_pin_n_in),
    .device_active_out(act), .channel_enable_out(en), .soft_shutdown_bit_out(soft_shutdown_bit),
    .breathing_control_out(breath), .operating_mode_out(mode), .current_setting_out(cur),
    .channel_on_out(on), .duty_out(duty), .start_time_out(st), .rise_time_out(rise),
    .fall_time_out(fall)
  );

  ledi2c_ctrl_model u_ctrl (
    .clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_drv_out(sda_drv)
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$], input int exp_acks);
    int n;
    u_ctrl.write(ADR, 1'b0, ptr, d, n);
    check(32'(n), 32'(exp_acks));
  endtask

  task automatic check_defaults();
    check({act, en, soft_shutdown_bit, on}, {3'b001, 3'h7});
    check({breath, mode, cur}, 24'h0);
    check({8'h0, duty}, 32'h0);
    check({8'h0, st | rise | fall}, 32'h0);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    final_report();
  end

  initial begin
    int n;
    failures = 0;
    tests_run = 0;
    sys_rst_in = 1'b1;
    shutdown_pin_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check_defaults();
    $display("test reset defaults done");

    u_ctrl.write(7'h6a, 1'b0, 8'h00, {8'h20}, n);
    check(32'(n), 32'h0);
    u_ctrl.write(ADR, 1'b1, 8'h00, {8'h20}, n);
    check(32'(n), 32'h0);
    check({31'h0, soft_shutdown_bit}, 32'h1);
    $display("test foreign address done");

    wr(8'h00, {8'h20}, 3);
    check({29'h0, act, en, soft_shutdown_bit}, 32'h6);
    shutdown_pin_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({31'h0, act}, 32'h0);
    shutdown_pin_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    check({31'h0, act}, 32'h1);
    $display("test shutdown control done");

    wr(8'h01, {8'h11, 8'h22, 8'h33}, 5);
    check({8'h0, breath, mode, cur}, 32'h112233);
    $display("test auto increment done");

    wr(8'h04, {8'h80, 8'h40, 8'hc8}, 5);
    wr(8'h1d, {8'h05}, 3);
    check({5'h0, on, duty}, {8'h7, 24'h0});
    wr(8'h07, {ledi2c_pkg::LOAD_VALUE}, 3);
    check({5'h0, on, duty}, {8'h5, 24'hc84080});
    $display("test duty load done");

    wr(8'h0a, {8'h01, 8'h02, 8'h03, 8'ha0, 8'ha1, 8'ha2, 8'h04, 8'h05, 8'h06}, 11);
    wr(8'h16, {8'h07, 8'h08, 8'h09}, 5);
    wr(8'h30, {8'hff}, 3);
    check({8'h0, st | rise | fall}, 32'h0);
    wr(8'h1c, {ledi2c_pkg::LOAD_VALUE}, 3);
    check({8'h0, st}, 32'h030201);
    check({8'h0, rise}, 32'h060504);
    check({8'h0, fall}, 32'h090807);
    $display("test timing load done");

    wr(8'h2f, {8'h00}, 3);
    check_defaults();
    $display("test soft reset done");
    final_report();
  end
endmodule
`default_nettype wire
